// >>> hw/exec_ops_pkg.sv
// Package for the rotate, subtract, skip and logic execution slice
package exec_ops_pkg;

    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int DATA_W = 8;      // Byte width of the datapath
    localparam int BIT_SEL_W = 3;   // Width of the bit selector
    localparam int TOP_BIT = 7;     // Most significant bit position
    localparam int LOW_BIT = 0;     // Least significant bit position
    localparam int NIB_TOP = 3;     // Top bit of the low nibble

    // ------------------------------------------------------------
    // Reset values and byte constants
    // ------------------------------------------------------------
    localparam logic [7:0] WORK_RST = 8'h00;  // Work register after reset
    localparam logic FLAG_RST = 1'b0;         // Every flag after reset
    localparam logic [7:0] ALL_ONES = 8'hff;  // Whole-byte set pattern
    localparam logic [7:0] ONE_BYTE = 8'h01;  // Step for increment and decrement

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam int SKIP_DUMMY_CYCLES = 1;     // Extra cycle spent by a taken skip

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE,
        ROTATE_LEFT_VIA_FLAG_MEM,
        ROTATE_LEFT_VIA_FLAG_TO_WORK,
        ROTATE_DOWN_MEM,
        ROTATE_DOWN_TO_WORK,
        ROTATE_DOWN_VIA_FLAG_MEM,
        ROTATE_DOWN_VIA_FLAG_TO_WORK,
        SUBTRACT_WITH_BORROW,
        SUBTRACT_WITH_BORROW_TO_MEM,
        SUBTRACT_MEM,
        SUBTRACT_TO_MEM,
        SUBTRACT_LITERAL,
        DECREMENT_THEN_TEST,
        DECREMENT_THEN_TEST_TO_WORK,
        INCREMENT_THEN_TEST,
        INCREMENT_THEN_TEST_TO_WORK,
        TEST_BIT_NONZERO,
        TEST_BIT_ZERO,
        TEST_ZERO,
        TEST_ZERO_COPY_TO_WORK,
        SET_BIT,
        SET_BYTE,
        EXCLUSIVE_OR_MEM,
        EXCLUSIVE_OR_LITERAL,
        EXCLUSIVE_OR_TO_MEM
    } op_t;

    // Sequencer state: accept a new operation or spend the dummy cycle
    typedef enum logic {
        ST_RUN,
        ST_DUMMY
    } seq_t;

endpackage : exec_ops_pkg

// >>> hw/exec_ops.sv
// Execution slice for rotates, subtracts, skips, bit set and exclusive-OR
`timescale 1ns/1ps

module exec_ops
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Operation request
    input wire logic op_valid,
    input wire exec_ops_pkg::op_t op_code,
    input wire logic [7:0] op_mem,
    input wire logic [7:0] op_lit,
    input wire logic [2:0] op_bit,
    output logic op_ready,
    // Data memory write-back
    output logic mem_wr_en,
    output logic [7:0] mem_wr_data,
    // Processor state
    output logic [7:0] work_reg,
    output logic carry_flag,
    output logic half_borrow_flag,
    output logic signed_wrap_flag,
    output logic zero_flag,
    // Skip indication
    output logic skip_dummy
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // One-hot mask of the selected bit, shared by test and set
    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        logic [7:0] m;
        m = exec_ops_pkg::ONE_BYTE << sel;
        return m;
    endfunction : bit_mask

    // Add with inverted operand: returns {ov, ac, c, result}
    function automatic logic [10:0] sub_fn(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] low7;
        logic c7;
        full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        low = {1'b0, a[exec_ops_pkg::NIB_TOP:0]} + {1'b0, ~b[exec_ops_pkg::NIB_TOP:0]} + {4'h0, cin};
        low7 = {1'b0, a[6:0]} + {1'b0, ~b[6:0]} + {7'h00, cin};
        c7 = low7[exec_ops_pkg::TOP_BIT];
        return {c7 ^ full[exec_ops_pkg::DATA_W], low[4], full[exec_ops_pkg::DATA_W], full[7:0]};
    endfunction : sub_fn

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    exec_ops_pkg::seq_t seq_ff;          // Run or dummy cycle
    exec_ops_pkg::seq_t nxt_seq;
    logic [7:0] work_ff;                 // Work register
    logic [7:0] nxt_work;
    logic carry_ff;                      // Carry flag
    logic nxt_carry;
    logic half_ff;                       // Half borrow flag
    logic nxt_half;
    logic wrap_ff;                       // Signed wrap flag
    logic nxt_wrap;
    logic zero_ff;                       // Zero result flag
    logic nxt_zero;
    logic wr_en_ff;                      // Memory write strobe
    logic nxt_wr_en;
    logic [7:0] wr_data_ff;              // Memory write data
    logic [7:0] nxt_wr_data;
    logic ready_ff;                      // Ready for a new operation
    logic nxt_ready;
    logic dummy_ff;                      // Dummy cycle marker
    logic nxt_dummy;

    // Scratch values of the combinational process
    logic take;                          // Operation accepted this cycle
    logic skip;                          // Skip taken by this operation
    logic [10:0] sres;                   // Subtract result and flags
    logic [7:0] step;                    // Incremented, decremented or exclusive-OR result byte

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Decode the operation and compute results and flags
    always_comb
    begin
        nxt_seq = seq_ff;
        nxt_work = work_ff;
        nxt_carry = carry_ff;
        nxt_half = half_ff;
        nxt_wrap = wrap_ff;
        nxt_zero = zero_ff;
        nxt_wr_en = 1'b0;
        nxt_wr_data = wr_data_ff;
        skip = 1'b0;
        sres = 11'h000;
        step = 8'h00;
        take = op_valid && (seq_ff == exec_ops_pkg::ST_RUN);
        if (take)
        begin
            case (op_code)
                // Nine-bit left rotation back to the byte
                exec_ops_pkg::ROTATE_LEFT_VIA_FLAG_MEM:
                begin
                    nxt_wr_data = {op_mem[6:0], carry_ff};
                    nxt_wr_en = 1'b1;
                    nxt_carry = op_mem[exec_ops_pkg::TOP_BIT];
                end
                // Nine-bit left rotation into the work register
                exec_ops_pkg::ROTATE_LEFT_VIA_FLAG_TO_WORK:
                begin
                    nxt_work = {op_mem[6:0], carry_ff};
                    nxt_carry = op_mem[exec_ops_pkg::TOP_BIT];
                end
                // Eight-bit right rotation back to the byte
                exec_ops_pkg::ROTATE_DOWN_MEM:
                begin
                    nxt_wr_data = {op_mem[exec_ops_pkg::LOW_BIT], op_mem[7:1]};
                    nxt_wr_en = 1'b1;
                end
                // Eight-bit right rotation into the work register
                exec_ops_pkg::ROTATE_DOWN_TO_WORK:
                begin
                    nxt_work = {op_mem[exec_ops_pkg::LOW_BIT], op_mem[7:1]};
                end
                // Nine-bit right rotation back to the byte
                exec_ops_pkg::ROTATE_DOWN_VIA_FLAG_MEM:
                begin
                    nxt_wr_data = {carry_ff, op_mem[7:1]};
                    nxt_wr_en = 1'b1;
                    nxt_carry = op_mem[exec_ops_pkg::LOW_BIT];
                end
                // Nine-bit right rotation into the work register
                exec_ops_pkg::ROTATE_DOWN_VIA_FLAG_TO_WORK:
                begin
                    nxt_work = {carry_ff, op_mem[7:1]};
                    nxt_carry = op_mem[exec_ops_pkg::LOW_BIT];
                end
                // Subtracts with borrow-in from the carry
                exec_ops_pkg::SUBTRACT_WITH_BORROW, exec_ops_pkg::SUBTRACT_WITH_BORROW_TO_MEM:
                begin
                    sres = sub_fn(work_ff, op_mem, carry_ff);
                    {nxt_wrap, nxt_half, nxt_carry} = sres[10:8];
                    nxt_zero = (sres[7:0] == 8'h00);
                    if (op_code == exec_ops_pkg::SUBTRACT_WITH_BORROW_TO_MEM)
                    begin
                        nxt_wr_data = sres[7:0];
                        nxt_wr_en = 1'b1;
                    end
                    else
                    begin
                        nxt_work = sres[7:0];
                    end
                end
                // Subtracts of the byte without borrow-in
                exec_ops_pkg::SUBTRACT_MEM, exec_ops_pkg::SUBTRACT_TO_MEM:
                begin
                    sres = sub_fn(work_ff, op_mem, 1'b1);
                    {nxt_wrap, nxt_half, nxt_carry} = sres[10:8];
                    nxt_zero = (sres[7:0] == 8'h00);
                    if (op_code == exec_ops_pkg::SUBTRACT_TO_MEM)
                    begin
                        nxt_wr_data = sres[7:0];
                        nxt_wr_en = 1'b1;
                    end
                    else
                    begin
                        nxt_work = sres[7:0];
                    end
                end
                // Subtract of the literal
                exec_ops_pkg::SUBTRACT_LITERAL:
                begin
                    sres = sub_fn(work_ff, op_lit, 1'b1);
                    {nxt_wrap, nxt_half, nxt_carry} = sres[10:8];
                    nxt_zero = (sres[7:0] == 8'h00);
                    nxt_work = sres[7:0];
                end
                // Decrement then skip on zero
                exec_ops_pkg::DECREMENT_THEN_TEST, exec_ops_pkg::DECREMENT_THEN_TEST_TO_WORK:
                begin
                    step = op_mem - exec_ops_pkg::ONE_BYTE;
                    skip = (step == 8'h00);
                    if (op_code == exec_ops_pkg::DECREMENT_THEN_TEST)
                    begin
                        nxt_wr_data = step;
                        nxt_wr_en = 1'b1;
                    end
                    else
                    begin
                        nxt_work = step;
                    end
                end
                // Increment then skip on zero
                exec_ops_pkg::INCREMENT_THEN_TEST, exec_ops_pkg::INCREMENT_THEN_TEST_TO_WORK:
                begin
                    step = op_mem + exec_ops_pkg::ONE_BYTE;
                    skip = (step == 8'h00);
                    if (op_code == exec_ops_pkg::INCREMENT_THEN_TEST)
                    begin
                        nxt_wr_data = step;
                        nxt_wr_en = 1'b1;
                    end
                    else
                    begin
                        nxt_work = step;
                    end
                end
                // Skip when the selected bit is set
                exec_ops_pkg::TEST_BIT_NONZERO:
                begin
                    skip = |(op_mem & bit_mask(op_bit));
                end
                // Skip when the selected bit is clear
                exec_ops_pkg::TEST_BIT_ZERO:
                begin
                    skip = ~|(op_mem & bit_mask(op_bit));
                end
                // Skip on a zero byte, optionally copying it
                exec_ops_pkg::TEST_ZERO, exec_ops_pkg::TEST_ZERO_COPY_TO_WORK:
                begin
                    skip = (op_mem == 8'h00);
                    if (op_code == exec_ops_pkg::TEST_ZERO_COPY_TO_WORK)
                    begin
                        nxt_work = op_mem;
                    end
                end
                // Force one bit high
                exec_ops_pkg::SET_BIT:
                begin
                    nxt_wr_data = op_mem | bit_mask(op_bit);
                    nxt_wr_en = 1'b1;
                end
                // Force the whole byte high
                exec_ops_pkg::SET_BYTE:
                begin
                    nxt_wr_data = exec_ops_pkg::ALL_ONES;
                    nxt_wr_en = 1'b1;
                end
                // Exclusive-OR into the work register
                exec_ops_pkg::EXCLUSIVE_OR_MEM, exec_ops_pkg::EXCLUSIVE_OR_LITERAL:
                begin
                    step = work_ff ^ ((op_code == exec_ops_pkg::EXCLUSIVE_OR_MEM) ? op_mem : op_lit);
                    nxt_work = step;
                    nxt_zero = (step == 8'h00);
                end
                // Exclusive-OR back to the byte
                exec_ops_pkg::EXCLUSIVE_OR_TO_MEM:
                begin
                    step = work_ff ^ op_mem;
                    nxt_wr_data = step;
                    nxt_wr_en = 1'b1;
                    nxt_zero = (step == 8'h00);
                end
                // No operation
                default:
                begin
                    skip = 1'b0;
                end
            endcase
        end
        // A taken skip spends one dummy cycle before the next operation
        case (seq_ff)
            exec_ops_pkg::ST_RUN:
            begin
                if (skip)
                begin
                    nxt_seq = exec_ops_pkg::ST_DUMMY;
                end
            end
            exec_ops_pkg::ST_DUMMY:
            begin
                nxt_seq = exec_ops_pkg::ST_RUN;
            end
            default:
            begin
                nxt_seq = exec_ops_pkg::ST_RUN;
            end
        endcase
        nxt_dummy = (nxt_seq == exec_ops_pkg::ST_DUMMY);
        nxt_ready = (nxt_seq == exec_ops_pkg::ST_RUN);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Register every next value
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seq_ff <= exec_ops_pkg::ST_RUN;
            work_ff <= exec_ops_pkg::WORK_RST;
            carry_ff <= exec_ops_pkg::FLAG_RST;
            half_ff <= exec_ops_pkg::FLAG_RST;
            wrap_ff <= exec_ops_pkg::FLAG_RST;
            zero_ff <= exec_ops_pkg::FLAG_RST;
            wr_en_ff <= 1'b0;
            wr_data_ff <= 8'h00;
            ready_ff <= 1'b1;
            dummy_ff <= 1'b0;
        end
        else
        begin
            seq_ff <= nxt_seq;
            work_ff <= nxt_work;
            carry_ff <= nxt_carry;
            half_ff <= nxt_half;
            wrap_ff <= nxt_wrap;
            zero_ff <= nxt_zero;
            wr_en_ff <= nxt_wr_en;
            wr_data_ff <= nxt_wr_data;
            ready_ff <= nxt_ready;
            dummy_ff <= nxt_dummy;
        end
    end

    // Outputs straight from the flip-flops
    assign op_ready = ready_ff;
    assign mem_wr_en = wr_en_ff;
    assign mem_wr_data = wr_data_ff;
    assign work_reg = work_ff;
    assign carry_flag = carry_ff;
    assign half_borrow_flag = half_ff;
    assign signed_wrap_flag = wrap_ff;
    assign zero_flag = zero_ff;
    assign skip_dummy = dummy_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    AST_RLC_MEM: assert property (take && op_code == exec_ops_pkg::ROTATE_LEFT_VIA_FLAG_MEM |=> mem_wr_en && mem_wr_data == {$past(op_mem[6:0]), $past(carry_ff)} && carry_ff == $past(op_mem[7])) else $error("left rotate via carry wrong");
    AST_RLC_WORK: assert property (take && op_code == exec_ops_pkg::ROTATE_LEFT_VIA_FLAG_TO_WORK |=> !mem_wr_en && work_ff == {$past(op_mem[6:0]), $past(carry_ff)}) else $error("left rotate to work wrong");
    AST_RR_MEM: assert property (take && op_code == exec_ops_pkg::ROTATE_DOWN_MEM |=> mem_wr_en && mem_wr_data == {$past(op_mem[0]), $past(op_mem[7:1])} && $stable(carry_ff)) else $error("right rotate wrong");
    AST_RR_WORK: assert property (take && op_code == exec_ops_pkg::ROTATE_DOWN_TO_WORK |=> !mem_wr_en && work_ff == {$past(op_mem[0]), $past(op_mem[7:1])} && $stable(zero_ff)) else $error("right rotate to work wrong");
    AST_RRC_MEM: assert property (take && op_code == exec_ops_pkg::ROTATE_DOWN_VIA_FLAG_MEM |=> mem_wr_data == {$past(carry_ff), $past(op_mem[7:1])} && carry_ff == $past(op_mem[0])) else $error("right rotate via carry wrong");
    AST_RRC_WORK: assert property (take && op_code == exec_ops_pkg::ROTATE_DOWN_VIA_FLAG_TO_WORK |=> work_ff == {$past(carry_ff), $past(op_mem[7:1])} && $stable(zero_ff)) else $error("right rotate via carry to work wrong");
    AST_SBC: assert property (take && op_code == exec_ops_pkg::SUBTRACT_WITH_BORROW |=> {carry_ff, work_ff} == 9'({1'b0, $past(work_ff)} + {1'b0, ~$past(op_mem)} + {8'h00, $past(carry_ff)})) else $error("subtract with borrow wrong");
    AST_SUBTRACT_TO_MEM: assert property (take && op_code == exec_ops_pkg::SUBTRACT_TO_MEM |=> mem_wr_en && mem_wr_data == 8'($past(work_ff) - $past(op_mem)) && zero_ff == (mem_wr_data == 8'h00)) else $error("subtract to memory wrong");
    AST_SUBL: assert property (take && op_code == exec_ops_pkg::SUBTRACT_LITERAL |=> work_ff == 8'($past(work_ff) - $past(op_lit)) && carry_ff == ($past(work_ff) >= $past(op_lit))) else $error("subtract literal wrong");
    AST_SKIP_DUMMY: assert property (take && skip |=> skip_dummy && !op_ready ##1 !skip_dummy && op_ready) else $error("skip dummy cycle wrong");
    AST_NO_SKIP: assert property (take && !skip |=> !skip_dummy) else $error("dummy without skip");
    AST_SET_BIT: assert property (take && op_code == exec_ops_pkg::SET_BIT |=> mem_wr_data[$past(op_bit)] && ((mem_wr_data ^ $past(op_mem)) & ~bit_mask($past(op_bit))) == 8'h00) else $error("bit set wrong");
    AST_XOR_FLAGS: assert property (take && op_code == exec_ops_pkg::EXCLUSIVE_OR_LITERAL |=> $stable(carry_ff) && zero_ff == (work_ff == 8'h00)) else $error("xor flags wrong");
    AST_SET_BYTE: assert property (take && op_code == exec_ops_pkg::SET_BYTE |=> mem_wr_en && mem_wr_data == exec_ops_pkg::ALL_ONES) else $error("byte set wrong");

    COV_SKIP_DEC: cover property (take && op_code == exec_ops_pkg::DECREMENT_THEN_TEST && skip);
    COV_SKIP_INC: cover property (take && op_code == exec_ops_pkg::INCREMENT_THEN_TEST_TO_WORK && skip);
    COV_SBC_BORROW: cover property (take && op_code == exec_ops_pkg::SUBTRACT_WITH_BORROW ##1 !carry_ff);

endmodule : exec_ops

// >>> verif/exec_ops_tb.sv
// Self-checking bench for the rotate, subtract, skip and logic execution slice
`timescale 1ns/1ps
module exec_ops_tb;
    // ------------------------------------------------------------
    // Stimulus, observed outputs and counters
    // ------------------------------------------------------------
    logic ref_clk = 1'b0; // System clock
    logic arst_n = 1'b0; // Core reset, active low
    logic op_valid = 1'b0; // Request strobe
    exec_ops_pkg::op_t op_code = exec_ops_pkg::OP_NONE; // Requested operation
    logic [7:0] op_mem = 8'h00; // Addressed byte
    logic [7:0] op_lit = 8'h00; // Literal, always the complement of op_mem so a wrong source shows
    logic [2:0] op_bit = 3'h0; // Bit selector
    logic op_ready, mem_wr_en, skip_dummy; // Handshake, write pulse, dummy marker
    logic [7:0] mem_wr_data, work_reg; // Write-back byte and work register
    logic carry_flag, half_borrow_flag, signed_wrap_flag, zero_flag; // Status flags
    logic [7:0] last_wr = 8'h00; // Last byte expected on the write-back port
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0; // Hang guard
    exec_ops DUT (.ref_clk(ref_clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
        .op_mem(op_mem), .op_lit(op_lit), .op_bit(op_bit), .op_ready(op_ready), .mem_wr_en(mem_wr_en),
        .mem_wr_data(mem_wr_data), .work_reg(work_reg), .carry_flag(carry_flag),
        .half_borrow_flag(half_borrow_flag), .signed_wrap_flag(signed_wrap_flag), .zero_flag(zero_flag),
        .skip_dummy(skip_dummy));
    // Free-running 100 MHz clock
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Cut a hang short well beyond the fifty or so cycles the sequence needs
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            $display("mismatch at %0t: run did not finish", $time);
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Verdict and end of run
    task conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // Compare a bundle of outputs
    task chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: outputs %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Issue one operation once ready, then check the cycle after the taking edge
    task run(input exec_ops_pkg::op_t c, input logic [7:0] m, input logic [2:0] b, input logic w,
        input logic [7:0] d, input logic [7:0] wk, input logic [3:0] f, input logic s);
        while (op_ready !== 1'b1)
            @(posedge ref_clk) #1;
        op_valid <= 1'b1;
        op_code <= c;
        op_mem <= m;
        op_lit <= ~m;
        op_bit <= b;
        @(posedge ref_clk);
        #1;
        if (w)
            last_wr = d;
        chk({mem_wr_en, mem_wr_data, work_reg, carry_flag, half_borrow_flag, signed_wrap_flag, zero_flag,
            skip_dummy, op_ready}, {w, last_wr, wk, f, s, ~s});
    endtask : run
    // ------------------------------------------------------------
    // Main sequence, flags packed as carry, half, wrap, zero
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk({work_reg, carry_flag, half_borrow_flag, signed_wrap_flag, zero_flag, op_ready, mem_wr_en, skip_dummy},
            {8'h00, 4'h0, 1'b1, 1'b0, 1'b0});
        run(exec_ops_pkg::EXCLUSIVE_OR_LITERAL, 8'h5a, 3'h0, 1'b0, 8'h00, 8'ha5, 4'h0, 1'b0);
        run(exec_ops_pkg::SUBTRACT_LITERAL, 8'hfc, 3'h0, 1'b0, 8'h00, 8'ha2, 4'hc, 1'b0);
        run(exec_ops_pkg::ROTATE_LEFT_VIA_FLAG_MEM, 8'h81, 3'h0, 1'b1, 8'h03, 8'ha2, 4'hc, 1'b0);
        run(exec_ops_pkg::ROTATE_LEFT_VIA_FLAG_TO_WORK, 8'h40, 3'h0, 1'b0, 8'h00, 8'h81, 4'h4, 1'b0);
        run(exec_ops_pkg::ROTATE_DOWN_VIA_FLAG_MEM, 8'h01, 3'h0, 1'b1, 8'h00, 8'h81, 4'hc, 1'b0);
        run(exec_ops_pkg::ROTATE_DOWN_VIA_FLAG_TO_WORK, 8'h02, 3'h0, 1'b0, 8'h00, 8'h81, 4'h4, 1'b0);
        run(exec_ops_pkg::ROTATE_DOWN_MEM, 8'h01, 3'h0, 1'b1, 8'h80, 8'h81, 4'h4, 1'b0);
        run(exec_ops_pkg::ROTATE_DOWN_TO_WORK, 8'h06, 3'h0, 1'b0, 8'h00, 8'h03, 4'h4, 1'b0);
        run(exec_ops_pkg::SUBTRACT_WITH_BORROW, 8'h03, 3'h0, 1'b0, 8'h00, 8'hff, 4'h0, 1'b0);
        run(exec_ops_pkg::SUBTRACT_WITH_BORROW_TO_MEM, 8'h7f, 3'h0, 1'b1, 8'h7f, 8'hff, 4'ha, 1'b0);
        run(exec_ops_pkg::SUBTRACT_MEM, 8'hff, 3'h0, 1'b0, 8'h00, 8'h00, 4'hd, 1'b0);
        run(exec_ops_pkg::SUBTRACT_TO_MEM, 8'h01, 3'h0, 1'b1, 8'hff, 8'h00, 4'h0, 1'b0);
        run(exec_ops_pkg::EXCLUSIVE_OR_MEM, 8'h3c, 3'h0, 1'b0, 8'h00, 8'h3c, 4'h0, 1'b0);
        run(exec_ops_pkg::EXCLUSIVE_OR_TO_MEM, 8'h3c, 3'h0, 1'b1, 8'h00, 8'h3c, 4'h1, 1'b0);
        run(exec_ops_pkg::SET_BIT, 8'h81, 3'h5, 1'b1, 8'ha1, 8'h3c, 4'h1, 1'b0);
        run(exec_ops_pkg::SET_BYTE, 8'h12, 3'h0, 1'b1, 8'hff, 8'h3c, 4'h1, 1'b0);
        run(exec_ops_pkg::DECREMENT_THEN_TEST, 8'h01, 3'h0, 1'b1, 8'h00, 8'h3c, 4'h1, 1'b1);
        // A request held through the dummy cycle is ignored
        op_code <= exec_ops_pkg::SET_BYTE;
        @(posedge ref_clk);
        #1;
        chk({mem_wr_en, skip_dummy, op_ready, mem_wr_data}, {1'b0, 1'b0, 1'b1, last_wr});
        run(exec_ops_pkg::DECREMENT_THEN_TEST_TO_WORK, 8'h00, 3'h0, 1'b0, 8'h00, 8'hff, 4'h1, 1'b0);
        run(exec_ops_pkg::INCREMENT_THEN_TEST, 8'hff, 3'h0, 1'b1, 8'h00, 8'hff, 4'h1, 1'b1);
        run(exec_ops_pkg::INCREMENT_THEN_TEST_TO_WORK, 8'h41, 3'h0, 1'b0, 8'h00, 8'h42, 4'h1, 1'b0);
        run(exec_ops_pkg::TEST_BIT_NONZERO, 8'h08, 3'h3, 1'b0, 8'h00, 8'h42, 4'h1, 1'b1);
        run(exec_ops_pkg::TEST_BIT_NONZERO, 8'hf7, 3'h3, 1'b0, 8'h00, 8'h42, 4'h1, 1'b0);
        run(exec_ops_pkg::TEST_BIT_ZERO, 8'hf7, 3'h3, 1'b0, 8'h00, 8'h42, 4'h1, 1'b1);
        run(exec_ops_pkg::TEST_BIT_ZERO, 8'h08, 3'h3, 1'b0, 8'h00, 8'h42, 4'h1, 1'b0);
        run(exec_ops_pkg::TEST_ZERO, 8'h00, 3'h0, 1'b0, 8'h00, 8'h42, 4'h1, 1'b1);
        run(exec_ops_pkg::TEST_ZERO, 8'h01, 3'h0, 1'b0, 8'h00, 8'h42, 4'h1, 1'b0);
        run(exec_ops_pkg::TEST_ZERO_COPY_TO_WORK, 8'h00, 3'h0, 1'b0, 8'h00, 8'h00, 4'h1, 1'b1);
        run(exec_ops_pkg::TEST_ZERO_COPY_TO_WORK, 8'h5a, 3'h0, 1'b0, 8'h00, 8'h5a, 4'h1, 1'b0);
        run(exec_ops_pkg::OP_NONE, 8'hff, 3'h0, 1'b0, 8'h00, 8'h5a, 4'h1, 1'b0);
        op_valid <= 1'b0;
        @(posedge ref_clk);
        conclude();
    end
endmodule : exec_ops_tb
